// file: design/disk_cmd_engine.sv
// command engine: status, deleted write, error read, track format, restart
//
// Chosen here: the valid-and-code command port and the word-move handshake.
`timescale 1ns/100ps
`include "disk_cmd_defines.svh"
module disk_cmd_engine
(
   // clock and reset
   input  wire logic                      clock_in,
   input  wire logic                      reset_in,
   // power and straps
   input  wire logic                      power_ok_in,
   input  wire logic                      mode2_in,
   input  wire logic                      irq_enable_in,
   // host command side
   input  wire logic                      cmd_valid_in,
   input  wire logic [2:0]                cmd_code_in,
   input  wire logic                      cmd_density_in,
   input  wire logic                      cmd_unit_in,
   input  wire logic                      move_data_word_in,
   input  wire logic [11:0]               host_word_in,
   input  wire logic                      skip_on_xfer_request_in,
   input  wire logic                      skip_on_done_in,
   // drive and self-test side
   input  wire disk_cmd_pkg::drive_stat_t drive_in,
   input  wire logic                      test_done_in,
   input  wire logic                      test_fail_in,
   input  wire logic [3:0]                test_code_in,
   // host outputs
   output disk_cmd_pkg::host_side_t       host_out,
   output logic                           irq_out,
   // drive outputs
   output logic                           head_load_out,
   output logic                           seek_out,
   output logic [7:0]                     track_out,
   output logic [4:0]                     sector_out,
   output logic                           write_out,
   output logic                           write_deleted_out,
   output logic                           read_out,
   output logic                           format_double_out,
   output logic                           test_start_out,
   output logic [8:0]                     led_out
);
   typedef struct packed {
      disk_cmd_pkg::state_t st;
      disk_cmd_pkg::host_side_t h;
      logic [7:0]  es;
      logic [7:0]  err;
      logic [1:0]  step;
      logic [`CNT_W-1:0] cnt;
      logic        saw_index;
      logic        cmd_den;
      logic [4:0]  idx;
      logic [7:0]  track;
      logic [4:0]  sector;
      logic        head;
      logic        seek;
      logic        wr;
      logic        wr_del;
      logic        wr_dm;
      logic        rd;
      logic        dbl;
      logic        tstart;
      logic        irq;
      logic [8:0]  led;
      logic        done_prev;
   } state_all_t;

   state_all_t s_r;
   state_all_t s_nxt;
   logic [7:0] mem_rd;
   logic       mem_we;

   // one word moved into the register counts once per move
   function automatic logic took_word(input logic mv, input logic req);
      took_word = mv & ~req;
   endfunction : took_word

   sector_order_mem u_mem
   (
      .clock_in    (clock_in),
      .wr_en_in    (mem_we),
      .wr_idx_in   (s_r.idx),
      .wr_data_in  (host_word_in[7:0]),
      .rd_idx_in   (s_r.idx),
      .rd_data_out (mem_rd)
   );

   // low eight bits of each sector word are stored exactly as delivered
   assign mem_we = (s_r.st == disk_cmd_pkg::ST_FMT_SEC)
                   && took_word(move_data_word_in, s_r.h.xfer_req);

   // next state of the whole engine
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.irq = 1'b0;
      s_nxt.tstart = 1'b0;
      s_nxt.done_prev = s_r.h.done;
      if (skip_on_xfer_request_in)
      begin
         s_nxt.h.xfer_req = 1'b0;
      end
      case (s_r.st)
         disk_cmd_pkg::ST_IDLE:
         begin
            s_nxt.led[`LED_WAIT] = 1'b1;
            if (cmd_valid_in)
            begin
               s_nxt.h.done = 1'b0;
               s_nxt.led[`LED_WAIT] = 1'b0;
               s_nxt.cmd_den = cmd_density_in;
               s_nxt.cnt = '0;
               s_nxt.saw_index = 1'b0;
               case (cmd_code_in)
                  `FN_STATUS:
                  begin
                     s_nxt.es[`ES_INIT_DONE] = 1'b0;
                     s_nxt.st = disk_cmd_pkg::ST_STATUS;
                  end
                  `FN_READ_ERR:
                  begin
                     s_nxt.h.data = {4'h0, s_r.err};
                     s_nxt.h.done = 1'b1;
                  end
                  `FN_WRITE, `FN_WRITE_DEL:
                  begin
                     s_nxt.es = '0;
                     s_nxt.h.xfer_req = 1'b1;
                     s_nxt.wr_del = (cmd_code_in == `FN_WRITE_DEL);
                     s_nxt.st = disk_cmd_pkg::ST_WSEC;
                  end
                  default:
                  begin
                     s_nxt.h.data = {4'h0, s_r.es};
                     s_nxt.h.done = 1'b1;
                  end
               endcase
            end
         end
         // ready needs two index edges within the speed window
         disk_cmd_pkg::ST_STATUS:
         begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (drive_in.index && drive_in.ready)
            begin
               s_nxt.saw_index = 1'b1;
            end
            if (s_r.saw_index && drive_in.index && drive_in.ready && s_r.cnt != '0)
            begin
               s_nxt.es[`ES_READY] = 1'b1;
               s_nxt.st = mode2_in ? disk_cmd_pkg::ST_DENS : disk_cmd_pkg::ST_IDLE;
            end
            else if (!drive_in.ready || s_r.cnt == `CNT_W'(`INDEX_WAIT_CYC))
            begin
               s_nxt.es[`ES_READY] = 1'b0;
               s_nxt.st = disk_cmd_pkg::ST_IDLE;
            end
            if (s_nxt.st == disk_cmd_pkg::ST_IDLE)
            begin
               // deleted, parity and crc bits untouched here
               s_nxt.h.data = {4'h0, s_nxt.es};
               s_nxt.h.done = 1'b1;
            end
         end
         // load head where it is and read the sector now addressed
         disk_cmd_pkg::ST_DENS:
         begin
            s_nxt.head = 1'b1;
            s_nxt.rd = 1'b1;
            if (drive_in.op_done)
            begin
               s_nxt.rd = 1'b0;
               s_nxt.head = 1'b0;
               s_nxt.es[`ES_DEN] = drive_in.density;
               if (drive_in.density != s_r.cmd_den)
               begin
                  s_nxt.es[`ES_DEN_ERR] = 1'b1;
               end
               s_nxt.h.data = {4'h0, s_nxt.es};
               s_nxt.h.done = 1'b1;
               s_nxt.st = disk_cmd_pkg::ST_IDLE;
            end
         end
         // sector then track address, or divert to format
         disk_cmd_pkg::ST_WSEC:
         begin
            if (took_word(move_data_word_in, s_r.h.xfer_req))
            begin
               s_nxt.h.xfer_req = 1'b1;
               if (host_word_in == `FMT_SINGLE || host_word_in == `FMT_DOUBLE)
               begin
                  s_nxt.dbl = (host_word_in == `FMT_DOUBLE);
                  s_nxt.st = disk_cmd_pkg::ST_FMT_TRK;
               end
               else
               begin
                  s_nxt.sector = host_word_in[4:0];
                  s_nxt.st = disk_cmd_pkg::ST_WTRK;
               end
            end
         end
         // ordinary or deleted-mark sector write
         disk_cmd_pkg::ST_WTRK:
         begin
            if (!s_r.wr && took_word(move_data_word_in, s_r.h.xfer_req))
            begin
               s_nxt.track = host_word_in[7:0];
               s_nxt.wr = 1'b1;
               s_nxt.wr_dm = s_r.wr_del; // own flop keeps the pin glitch free
               s_nxt.head = 1'b1;
            end
            else if (s_r.wr && drive_in.op_done)
            begin
               s_nxt.wr = 1'b0;
               s_nxt.head = 1'b0;
               s_nxt.es[`ES_DELETED] = s_r.wr_del;
               s_nxt.wr_dm = 1'b0;
               s_nxt.h.data = {4'h0, s_nxt.es};
               s_nxt.h.done = 1'b1;
               s_nxt.st = disk_cmd_pkg::ST_IDLE;
            end
         end
         disk_cmd_pkg::ST_FMT_TRK:
         begin
            if (took_word(move_data_word_in, s_r.h.xfer_req))
            begin
               s_nxt.track = host_word_in[7:0];
               s_nxt.idx = '0;
               s_nxt.h.xfer_req = 1'b1;
               s_nxt.st = disk_cmd_pkg::ST_FMT_SEC;
            end
         end
         // no range or uniqueness check on sector words
         disk_cmd_pkg::ST_FMT_SEC:
         begin
            if (took_word(move_data_word_in, s_r.h.xfer_req))
            begin
               if (s_r.idx == `FMT_LAST_IDX)
               begin
                  s_nxt.idx = '0;
                  s_nxt.seek = 1'b1;
                  s_nxt.head = 1'b1;
                  s_nxt.st = disk_cmd_pkg::ST_FMT_SEEK;
               end
               else
               begin
                  s_nxt.idx = s_r.idx + 1'b1;
                  s_nxt.h.xfer_req = 1'b1;
               end
            end
         end
         // seek, then wait for index before writing
         disk_cmd_pkg::ST_FMT_SEEK:
         begin
            if (drive_in.op_done)
            begin
               s_nxt.seek = 1'b0;
            end
            if (!s_r.seek && drive_in.index)
            begin
               s_nxt.wr = 1'b1;
               s_nxt.st = disk_cmd_pkg::ST_FMT_WRITE;
            end
         end
         // each header done steps to next stored sector
         disk_cmd_pkg::ST_FMT_WRITE:
         begin
            s_nxt.sector = mem_rd[4:0];
            if (drive_in.op_done)
            begin
               if (s_r.idx == `FMT_LAST_IDX)
               begin
                  s_nxt.wr = 1'b0;
                  s_nxt.head = 1'b0;
                  s_nxt.h.data = {4'h0, s_r.es};
                  s_nxt.h.done = 1'b1;
                  s_nxt.st = disk_cmd_pkg::ST_IDLE;
               end
               else
               begin
                  s_nxt.idx = s_r.idx + 1'b1;
               end
            end
         end
         // self-tests with the failure code shown first
         disk_cmd_pkg::ST_SELFTEST:
         begin
            s_nxt.led[7:4] = test_code_in;
            if (s_r.step == 2'd0)
            begin
               s_nxt.tstart = 1'b1;
               s_nxt.step = 2'd1;
            end
            else if (test_fail_in)
            begin
               s_nxt.led = '0;
               s_nxt.led[7:4] = test_code_in;
               s_nxt.led[`LED_WAIT] = 1'b1;
               s_nxt.st = disk_cmd_pkg::ST_HALT;
            end
            else if (test_done_in)
            begin
               s_nxt.seek = 1'b1;
               s_nxt.track = `HOME_TRACK;
               s_nxt.st = disk_cmd_pkg::ST_RECAL;
            end
         end
         disk_cmd_pkg::ST_RECAL:
         begin
            if (drive_in.op_done)
            begin
               s_nxt.seek = 1'b0;
               s_nxt.es = '0;
               s_nxt.err = `ERR_NONE;
               if (drive_in.ready)
               begin
                  s_nxt.track = `RESTART_TRACK;
                  s_nxt.sector = `RESTART_SECTOR;
                  s_nxt.rd = 1'b1;
                  s_nxt.head = 1'b1;
               end
               s_nxt.st = disk_cmd_pkg::ST_BOOT;
            end
         end
         disk_cmd_pkg::ST_BOOT:
         begin
            if (!s_r.rd || drive_in.op_done)
            begin
               s_nxt.rd = 1'b0;
               s_nxt.head = 1'b0;
               s_nxt.es[`ES_INIT_DONE] = 1'b1;
               s_nxt.es[`ES_READY] = drive_in.ready;
               s_nxt.es[`ES_DEN] = mode2_in ? drive_in.density : 1'b0;
               s_nxt.h.data = {4'h0, s_nxt.es};
               s_nxt.h.done = 1'b1;
               s_nxt.st = disk_cmd_pkg::ST_IDLE;
            end
         end
         // a fault stops everything until reset or a power loss
         disk_cmd_pkg::ST_HALT:
         begin
            s_nxt.h.xfer_req = 1'b0;
         end
         disk_cmd_pkg::ST_DOWN:
         begin
            if (power_ok_in)
            begin
               s_nxt.step = 2'd0;
               s_nxt.st = disk_cmd_pkg::ST_SELFTEST;
            end
         end
         default:
         begin
            s_nxt.st = disk_cmd_pkg::ST_IDLE;
         end
      endcase
      // drive reports of deleted mark and faults during reads
      if (s_r.rd && drive_in.op_done)
      begin
         s_nxt.es[`ES_DELETED] = s_nxt.es[`ES_DELETED] | drive_in.deleted_seen;
         s_nxt.es[`ES_CRC] = s_nxt.es[`ES_CRC] | drive_in.crc_fault;
         s_nxt.es[`ES_PARITY] = s_nxt.es[`ES_PARITY] | drive_in.parity_fault;
      end
      // done rising raises the interrupt when enabled
      // a code answered at once may find done already high; it still interrupts
      if (s_nxt.h.done && irq_enable_in
          && (!s_r.h.done || (s_r.st == disk_cmd_pkg::ST_IDLE && cmd_valid_in)))
      begin
         s_nxt.irq = 1'b1;
      end
      s_nxt.led[`LED_RUN] = (s_nxt.st != disk_cmd_pkg::ST_HALT);
      // power loss abandons all work and unloads head
      if (!power_ok_in)
      begin
         s_nxt.st = disk_cmd_pkg::ST_DOWN;
         s_nxt.head = 1'b0;
         s_nxt.seek = 1'b0;
         s_nxt.wr = 1'b0;
         s_nxt.wr_dm = 1'b0;
         s_nxt.rd = 1'b0;
         s_nxt.h.done = 1'b0;
         s_nxt.h.xfer_req = 1'b0;
         s_nxt.irq = 1'b0;
      end
   end

   // reset starts the self-tests; they cannot be skipped
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         s_r <= '0;
         s_r.st <= disk_cmd_pkg::ST_SELFTEST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign host_out = s_r.h;
   assign irq_out = s_r.irq;
   assign head_load_out = s_r.head;
   assign seek_out = s_r.seek;
   assign track_out = s_r.track;
   assign sector_out = s_r.sector;
   assign write_out = s_r.wr;
   assign write_deleted_out = s_r.wr_dm;
   assign read_out = s_r.rd;
   assign format_double_out = s_r.dbl;
   assign test_start_out = s_r.tstart;
   assign led_out = s_r.led;

   // status code clears init-done one cycle later
   a_status_init_clr: assert property (@(posedge clock_in) disable iff (reset_in)
      (s_r.st == disk_cmd_pkg::ST_IDLE && cmd_valid_in && cmd_code_in == `FN_STATUS
       && power_ok_in) |=> !s_r.es[`ES_INIT_DONE])
      else $error("init-done not cleared by status");
   a_err_code_out: assert property (@(posedge clock_in) disable iff (reset_in)
      (s_r.st == disk_cmd_pkg::ST_IDLE && cmd_valid_in && cmd_code_in == `FN_READ_ERR
       && power_ok_in) |=> (host_out.done && host_out.data[7:0] == $past(s_r.err)))
      else $error("error code not delivered");
   a_power_unload: assert property (@(posedge clock_in) disable iff (reset_in)
      !power_ok_in |=> (!head_load_out && !write_out && !host_out.done))
      else $error("head still loaded after power loss");
   a_status_keeps_bits: assert property (@(posedge clock_in) disable iff (reset_in)
      (s_r.st == disk_cmd_pkg::ST_STATUS && !s_r.rd) |=>
      (s_r.es[`ES_CRC] == $past(s_r.es[`ES_CRC])
       && s_r.es[`ES_PARITY] == $past(s_r.es[`ES_PARITY])))
      else $error("status changed fault bits");
   a_fmt_no_req: assert property (@(posedge clock_in) disable iff (reset_in)
      (s_r.st == disk_cmd_pkg::ST_FMT_SEEK) |-> !host_out.xfer_req)
      else $error("request raised after last sector");
   a_halt_leds: assert property (@(posedge clock_in) disable iff (reset_in)
      (s_r.st == disk_cmd_pkg::ST_HALT) |-> (!led_out[`LED_RUN] && led_out[`LED_WAIT]
       && !led_out[0] && !led_out[2] && !led_out[3]))
      else $error("halt led pattern wrong");
   a_skip_clears: assert property (@(posedge clock_in) disable iff (reset_in)
      skip_on_xfer_request_in |=> !host_out.xfer_req || $past(move_data_word_in))
      else $error("skip did not clear request");
   a_done_irq: assert property (@(posedge clock_in) disable iff (reset_in)
      (power_ok_in && irq_enable_in && !s_r.h.done && s_nxt.h.done) |=> irq_out)
      else $error("done without interrupt");
endmodule : disk_cmd_engine

// file: design/disk_cmd_defines.svh
// constants shared by the disk command engine files
`ifndef DISK_CMD_DEFINES_SVH
`define DISK_CMD_DEFINES_SVH
// function codes
`define FN_WRITE       3'h2
`define FN_STATUS      3'h5
`define FN_WRITE_DEL   3'h6
`define FN_READ_ERR    3'h7
// track format request codes, octal 152 and 153
`define FMT_SINGLE     12'h006A
`define FMT_DOUBLE     12'h006B
`define FMT_SECTORS    5'h1A
`define FMT_LAST_IDX   5'h19
// error/status bit positions
`define ES_CRC         0
`define ES_PARITY      1
`define ES_INIT_DONE   2
`define ES_DEN_ERR     4
`define ES_DEN         5
`define ES_DELETED     6
`define ES_READY       7
// error codes
`define ERR_NONE       8'h00
// restart targets
`define RESTART_SECTOR 5'h01
`define RESTART_TRACK  8'h01
`define HOME_TRACK     8'h00
// time limits
`define INDEX_WAIT_MS  250
`define CLK_MHZ        250
`define INDEX_WAIT_CYC (`INDEX_WAIT_MS * 1000 * `CLK_MHZ)
`define CNT_W          26
// led indicator bits
`define LED_RUN        8
`define LED_WAIT       1
`endif

// file: design/disk_cmd_pkg.sv
// types shared by the disk command engine files
package disk_cmd_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_SELFTEST, ST_RECAL, ST_BOOT, ST_STATUS, ST_DENS,
      ST_WSEC, ST_WTRK, ST_FMT_TRK, ST_FMT_SEC, ST_FMT_SEEK, ST_FMT_WRITE,
      ST_HALT, ST_DOWN
   } state_t;

   // words and flags seen by the host through the interface register
   typedef struct packed {
      logic [11:0] data;
      logic        xfer_req;
      logic        done;
      logic        error;
   } host_side_t;

   // status and answers from the drive mechanics
   typedef struct packed {
      logic        ready;
      logic        index;
      logic        density;
      logic        op_done;
      logic        deleted_seen;
      logic        crc_fault;
      logic        parity_fault;
   } drive_stat_t;
endpackage : disk_cmd_pkg

// file: design/sector_order_mem.sv
// small memory that keeps the sector numbers of a track in delivery order
`timescale 1ns/100ps
`include "disk_cmd_defines.svh"
module sector_order_mem
(
   // clock
   input  wire logic       clock_in,
   // write side
   input  wire logic       wr_en_in,
   input  wire logic [4:0] wr_idx_in,
   input  wire logic [7:0] wr_data_in,
   // read side
   input  wire logic [4:0] rd_idx_in,
   output logic      [7:0] rd_data_out
);
   logic [7:0] mem_r [0:31];

   // read data registered one cycle after the index
   always_ff @(posedge clock_in)
   begin
      if (wr_en_in)
      begin
         mem_r[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= mem_r[rd_idx_in];
   end
endmodule : sector_order_mem

// file: test/host_model.sv
// host program model: function codes, skip tests and word moves
`timescale 1ns/100ps
module host_model
(
   // clock and flags seen by the host
   input  wire logic                     clock_in,
   input  wire disk_cmd_pkg::host_side_t host_in,
   // command lines
   output logic                          cmd_valid_out,
   output logic [2:0]                    cmd_code_out,
   output logic                          cmd_density_out,
   // word and skip lines
   output logic                          move_out,
   output logic [11:0]                   word_out,
   output logic                          skip_xfer_out,
   output logic                          skip_done_out
);
   // idle lines at time zero; a released line never keeps a stale value, except density, which keeps its last value
   initial
   begin
      cmd_valid_out   = 1'b0;
      cmd_code_out    = 3'h0;
      cmd_density_out = 1'b0;
      move_out        = 1'b0;
      word_out        = 12'h0fff;
      skip_xfer_out   = 1'b0;
      skip_done_out   = 1'b0;
   end

   // one function code; callers wait for done first
   task automatic issue(input logic [2:0] code, input logic den);
      @(posedge clock_in);
      cmd_valid_out   <= 1'b1;
      cmd_code_out    <= code;
      cmd_density_out <= den;
      @(posedge clock_in);
      cmd_valid_out <= 1'b0;
      cmd_code_out  <= ~code;
   endtask : issue

   // wait for a request, skip on it, then move exactly one word
   task automatic send(input logic [11:0] w, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 500 && !ok; n++)
      begin
         @(posedge clock_in);
         ok = host_in.xfer_req === 1'b1;
      end
      skip_xfer_out <= 1'b1;
      @(posedge clock_in);
      skip_xfer_out <= 1'b0;
      move_out      <= 1'b1;
      word_out      <= w;
      @(posedge clock_in);
      move_out <= 1'b0;
      word_out <= ~w;
   endtask : send

   // poll done, then give one skip-on-done test before the word is read
   task automatic await_done(output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 4000 && !ok; n++)
      begin
         @(posedge clock_in);
         ok = host_in.done === 1'b1;
      end
      skip_done_out <= 1'b1;
      @(posedge clock_in);
      skip_done_out <= 1'b0;
   endtask : await_done
endmodule : host_model

// file: test/disk_cmd_engine_test.sv
// self-checking bench for the disk command engine
`timescale 1ns/100ps
`include "disk_cmd_defines.svh"
module disk_cmd_engine_test;
   logic                       clock_in, reset_in, power_ok, mode2, fail, ok, irq_en;
   logic                       cv, den, mv, sx, sd, ts, td, irq, hl, sk, rd, wr, wd, dbl, wds;
   logic [2:0]                 code;
   logic [11:0]                word;
   logic [31:0]                rnd;
   logic [7:0]                 trk, trk_o, skt, rec[26], sec[26];
   logic [4:0]                 sec_o;
   logic [8:0]                 led;
   int                         err_total, cmp_count, i, j, f, rec_n, late, irq_n, tick, opc, stc;
   disk_cmd_pkg::drive_stat_t  drv;
   disk_cmd_pkg::host_side_t   host;

   host_model u_host_model (.clock_in(clock_in), .host_in(host), .cmd_valid_out(cv),
      .cmd_code_out(code), .cmd_density_out(den), .move_out(mv), .word_out(word),
      .skip_xfer_out(sx), .skip_done_out(sd));
   disk_cmd_engine u_disk_cmd_engine (.clock_in(clock_in), .reset_in(reset_in),
      .power_ok_in(power_ok), .mode2_in(mode2), .irq_enable_in(irq_en), .cmd_valid_in(cv),
      .cmd_code_in(code), .cmd_density_in(den), .cmd_unit_in(1'b0), .move_data_word_in(mv),
      .host_word_in(word), .skip_on_xfer_request_in(sx), .skip_on_done_in(sd),
      .drive_in(drv), .test_done_in(td), .test_fail_in(td & fail), .test_code_in(4'h9),
      .host_out(host), .irq_out(irq), .head_load_out(hl), .seek_out(sk), .track_out(trk_o),
      .sector_out(sec_o), .write_out(wr), .write_deleted_out(wd), .read_out(rd),
      .format_double_out(dbl), .test_start_out(ts), .led_out(led));

   // drive side: index every 40 cycles, each operation ends 6 cycles in, tests take 4
   always @(posedge clock_in)
   begin
      tick <= (tick == 39) ? 0 : tick + 1;
      drv.index <= tick == 0;
      opc <= (sk | rd | wr | wd) ? opc + 1 : 0;
      drv.op_done <= (sk | rd | wr | wd) && (opc % 6 == 5);
      stc <= ts ? 1 : (stc != 0 ? stc + 1 : 0);
      td <= stc == 4;
      if (drv.op_done && wr && rec_n < 26)
         rec[rec_n] <= 8'(sec_o);
      if (drv.op_done && wr)
         rec_n <= rec_n + 1;
      if ((sk | wr) && host.xfer_req)
         late <= late + 1;
      if (sk)
         skt <= trk_o;
      if (irq)
         irq_n <= irq_n + 1;
      if (wd)
         wds <= 1'b1;
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp)
         begin
            err_total++;
            $display("CHECK FAILED t=%0t saw %h want %h", $time, got, exp);
         end
   endtask : chk

   task automatic finish_op();
      u_host_model.await_done(ok);
      chk(12'(ok), 12'h0001);
   endtask : finish_op

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   // reset held for twelve cycles; the restart sequence follows its release
   task automatic pulse_reset();
      reset_in <= 1'b1;
      repeat (12) @(posedge clock_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge clock_in);
   endtask : pulse_reset

   initial
   begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end

   // a hang counts as a mismatch and ends the run
   initial
   begin
      repeat (60000) @(posedge clock_in);
      err_total++;
      conclude();
   end

   initial
   begin
      {reset_in, power_ok, mode2, fail, td, wds, irq_en, rnd} = {7'h61, 32'h0000_6c5f};
      {drv, tick, opc, stc, rec_n, late, irq_n, err_total, cmp_count} = '0;
      drv.ready = 1'b1;
      pulse_reset();
      chk(12'(host.done), 12'h0000);
      finish_op();
      chk(12'(host.data[`ES_INIT_DONE]), 12'h0001);
      chk(12'(stc != 0), 12'h0001);
      chk(12'(skt), 12'h0000);
      $display("finished: restart");
      // status with a randomly ready drive; init-done always drops
      for (i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         drv.ready <= rnd[0];
         u_host_model.issue(`FN_STATUS, 1'b0);
         finish_op();
         chk(12'(host.data[`ES_READY]), 12'(rnd[0]));
         chk(12'(host.data[`ES_INIT_DONE]), 12'h0000);
      end
      {drv.ready, mode2, drv.density} <= 3'h7;
      u_host_model.issue(`FN_STATUS, 1'b0);
      finish_op();
      chk(12'(host.data[`ES_DEN]), 12'h0001);
      chk(12'(host.data[`ES_DEN_ERR]), 12'h0001);
      {mode2, drv.density} <= 2'h0;
      $display("finished: status");
      u_host_model.issue(`FN_WRITE_DEL, 1'b0);
      u_host_model.send(12'h0003, ok);
      u_host_model.send(12'h0005, ok);
      finish_op();
      chk(12'(host.data[`ES_DELETED]), 12'h0001);
      chk(12'(wds), 12'h0001);
      u_host_model.issue(`FN_STATUS, 1'b0);
      finish_op();
      chk(12'(host.data[`ES_DELETED]), 12'h0001);
      j = irq_n;
      u_host_model.issue(`FN_READ_ERR, 1'b0);
      finish_op();
      chk(host.data, 12'(`ERR_NONE));
      chk(12'(irq_n - j), 12'h0001);
      irq_en <= 1'b0;
      u_host_model.issue(`FN_READ_ERR, 1'b0);
      finish_op();
      chk(12'(irq_n - j), 12'h0001);
      irq_en <= 1'b1;
      $display("finished: deleted write and error code");
      // both track formats, sectors in a random interleave
      for (f = 0; f < 2; f++)
      begin
         for (i = 0; i < 26; i++)
            sec[i] = 8'(i + 1);
         for (i = 25; i > 0; i--)
         begin
            rnd = lfsr(rnd);
            j = int'(rnd % (i + 1));
            trk = sec[i];
            sec[i] = sec[j];
            sec[j] = trk;
         end
         rnd = lfsr(rnd);
         trk = 8'(rnd % 77);
         {rec_n, late} = '0;
         u_host_model.issue(`FN_WRITE, f[0]);
         u_host_model.send(f ? `FMT_DOUBLE : `FMT_SINGLE, ok);
         u_host_model.send({4'h0, trk}, ok);
         for (i = 0; i < 26; i++)
            u_host_model.send({4'h0, sec[i]}, ok);
         finish_op();
         chk(12'(late), 12'h0000);
         chk(12'(skt), 12'(trk));
         chk(12'(dbl), 12'(f));
         chk(12'(rec_n), 12'h001a);
         for (i = 0; i < 26; i++)
            chk(12'(rec[i]), 12'(sec[i]));
      end
      $display("finished: track format");
      u_host_model.issue(`FN_STATUS, 1'b0);
      repeat (3) @(posedge clock_in);
      power_ok <= 1'b0;
      repeat (4) @(posedge clock_in);
      chk(12'({hl, sk, rd, wr, host.done}), 12'h0000);
      {power_ok, drv.deleted_seen} <= 2'h3;
      finish_op();
      drv.deleted_seen <= 1'b0;
      u_host_model.issue(`FN_STATUS, 1'b0);
      finish_op();
      chk(12'(host.data[`ES_DELETED]), 12'h0001);
      $display("finished: power restart");
      fail <= 1'b1;
      pulse_reset();
      repeat (40) @(posedge clock_in);
      chk(12'(led), 12'h0092);
      chk(12'(host.done), 12'h0000);
      $display("finished: self-test fault");
      conclude();
   end
endmodule : disk_cmd_engine_test
